/* hw/cqac_addr_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// [RULE_01] RAM select low whenever a write slot or read slot is active.
// [RULE_02] Each pointer is a 16-bit LFSR with XOR feedback into stage one.
// [RULE_03] Taps give a maximal sequence of all states but one.
// [RULE_04] Reset clears both pointer registers to zero.
// [RULE_05] Last-stage feedback inverted; starts at zero, never reaches all ones.
// [RULE_06] Empty when read pointer equals store pointer.
// [RULE_07] Full when store pointer next value equals read pointer.
// [RULE_08] Comparisons built from per-bit XNOR terms.
// [RULE_09] Equality chained serially: each match ANDed with previous stage.
// [RULE_10] Both pointers multiplexed onto one 16-bit RAM address bus.
// [RULE_11] Reset input restarts every flip-flop of the controller.
// [RULE_12] Store pointer steps after write cycle, read pointer after read cycle.
// [RULE_13] Write request raised only when queue not full; byte waits otherwise.
// [RULE_14] Read started in next read slot only when queue not empty.
// [RULE_15] Address carries store pointer in write slot, read pointer in read slot.
// [RULE_16] Empty and full valid in the same cycle a pointer changes.
module cqac_addr_ctrl
   import cqac_pkg::*;
#(
   parameter int W = PTR_WIDTH
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_byte_pending,
   input wire logic i_write_phase,
   input wire logic i_read_phase,
   input wire logic i_read_hold,
   output logic o_pending_store_request,
   output logic o_write_slot_active,
   output logic o_read_slot_active,
   output logic o_write_done,
   output logic o_read_done,
   output logic o_ram_select_n,
   output logic [W-1:0] o_ram_addr,
   output logic o_empty,
   output logic o_full
);
   cqac_ptr_if #(.W(W)) store_if ();
   cqac_ptr_if #(.W(W)) read_if ();

   cqac_slot_type state;
   cqac_slot_type next_state;
   logic pending_store_request;
   logic next_pending_store_request;
   logic [W-1:0] ram_addr;
   logic [W-1:0] next_ram_addr;
   logic read_phase_prev;
   logic next_read_phase_prev;
   logic write_done;
   logic read_done;
   logic [W:0] empty_chain;
   logic [W:0] full_chain;

   // two pointer registers
   cqac_lfsr_ptr #(.W(W)) u_store_ptr
   (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .p(store_if)
   );

   cqac_lfsr_ptr #(.W(W)) u_read_ptr
   (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .p(read_if)
   );

   // serial xnor compare chains, combinational from live pointers
   assign empty_chain[0] = 1'b1;
   assign full_chain[0] = 1'b1;
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_cmp
         assign empty_chain[g+1] = empty_chain[g] &
            ~(read_if.value[g] ^ store_if.value[g]); // [RULE_06] [RULE_08] [RULE_09]
         assign full_chain[g+1] = full_chain[g] &
            ~(read_if.value[g] ^ store_if.next_value[g]); // [RULE_07] [RULE_08] [RULE_09]
      end
   endgenerate

   assign o_empty = empty_chain[W]; // [RULE_16]
   assign o_full = full_chain[W]; // [RULE_16]

   // slot end strobes step the pointers
   assign write_done = (state == CQAC_WRITE) && !i_write_phase;
   assign read_done = (state == CQAC_READ) && !i_read_phase;
   assign store_if.step = write_done; // [RULE_12]
   assign read_if.step = read_done; // [RULE_12]

   // slot sequencing and request flag
   always_comb
   begin
      next_state = state;
      next_pending_store_request = pending_store_request;
      next_ram_addr = ram_addr;
      next_read_phase_prev = i_read_phase; // phase level kept for its rising edge
      case (state)
         CQAC_IDLE:
         begin
            // request set only ahead of a write phase, and only with room
            if (i_byte_pending && !o_full && !i_write_phase)
            begin
               next_pending_store_request = 1'b1; // [RULE_13]
            end
            if (pending_store_request && i_write_phase)
            begin
               next_state = CQAC_WRITE;
               next_ram_addr = store_if.value; // [RULE_10] [RULE_15]
            end
            // a read opens only on the first cycle of a read phase, never part way in
            else if (!o_empty && !i_read_hold && i_read_phase && !read_phase_prev)
            begin
               next_state = CQAC_READ; // [RULE_14]
               next_ram_addr = read_if.value; // [RULE_10] [RULE_15]
            end
         end
         CQAC_WRITE:
         begin
            if (!i_write_phase)
            begin
               next_state = CQAC_IDLE;
               next_pending_store_request = 1'b0; // [RULE_12]
            end
         end
         CQAC_READ:
         begin
            if (!i_read_phase)
            begin
               next_state = CQAC_IDLE;
            end
         end
         default:
         begin
            next_state = CQAC_IDLE;
            next_pending_store_request = 1'b0;
         end
      endcase
   end

   // registers of the slot logic
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         state <= CQAC_IDLE; // [RULE_11]
         pending_store_request <= 1'b0;
         ram_addr <= PTR_RESET;
         read_phase_prev <= 1'b0;
      end
      else
      begin
         state <= next_state;
         pending_store_request <= next_pending_store_request;
         ram_addr <= next_ram_addr;
         read_phase_prev <= next_read_phase_prev;
      end
   end

   assign o_write_slot_active = (state == CQAC_WRITE);
   assign o_read_slot_active = (state == CQAC_READ);
   assign o_ram_select_n = ~(o_write_slot_active | o_read_slot_active); // [RULE_01]
   assign o_ram_addr = ram_addr;
   assign o_pending_store_request = pending_store_request;
   assign o_write_done = write_done;
   assign o_read_done = read_done;
endmodule

/* hw/cqac_lfsr_ptr.sv */
`timescale 1ns/1ps
module cqac_lfsr_ptr
   import cqac_pkg::*;
#(
   parameter int W = PTR_WIDTH
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   cqac_ptr_if.owner p
);
   logic [W-1:0] ptr;
   logic [W-1:0] next_ptr;
   logic feedback;

   // inverted last-stage feedback keeps the all-ones state out
   always_comb
   begin
      feedback = ~(ptr[TAP_A] ^ ptr[TAP_B] ^ ptr[TAP_C] ^ ptr[TAP_D]); // [RULE_02] [RULE_03] [RULE_05]
      next_ptr = {ptr[W-2:0], feedback}; // [RULE_02]
   end

   // pointer register, step only on request
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         ptr <= PTR_RESET; // [RULE_04] [RULE_11]
      end
      else if (p.step)
      begin
         ptr <= next_ptr; // [RULE_12]
      end
   end

   assign p.value = ptr;
   assign p.next_value = next_ptr; // d-input value for the full compare
endmodule

/* hw/cqac_pkg.sv */
package cqac_pkg;
   // pointer width and reset value
   localparam int PTR_WIDTH = 16;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   // feedback taps for x^16+x^15+x^13+x^4+1 (stage indices, 0-based)
   localparam int TAP_A = 15;
   localparam int TAP_B = 14;
   localparam int TAP_C = 12;
   localparam int TAP_D = 3;
   // slot states of the controller
   typedef enum logic [2:0]
   {
      CQAC_IDLE = 3'b001,
      CQAC_WRITE = 3'b010,
      CQAC_READ = 3'b100
   } cqac_slot_type;
endpackage

/* hw/cqac_ptr_if.sv */
`timescale 1ns/1ps
interface cqac_ptr_if #(parameter int W = 16);
   logic step;
   logic [W-1:0] value;
   logic [W-1:0] next_value;
   modport owner (input step, output value, output next_value);
   modport user (output step, input value, input next_value);
endinterface

/* tb/cqac_addr_ctrl_checker.sv */
`timescale 1ns/1ps
module cqac_addr_ctrl_checker
   import cqac_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_write_phase,
   input wire logic i_read_phase,
   input wire logic i_read_hold,
   input wire logic o_pending_store_request,
   input wire logic o_write_slot_active,
   input wire logic o_read_slot_active,
   input wire logic o_write_done,
   input wire logic o_read_done,
   input wire logic o_ram_select_n,
   input wire logic o_empty,
   input wire logic o_full
);
   // every pointer state but the excluded one, less the one kept free
   localparam int QUEUE_CAP = (1 << PTR_WIDTH) - 2;
   int occ;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // bytes held in the queue, counted from the slot end strobes
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         occ <= 0;
      end
      else if (o_write_done && !o_read_done)
      begin
         occ <= occ + 1;
      end
      else if (o_read_done && !o_write_done)
      begin
         occ <= occ - 1;
      end
   end
   // slot, select and queue-state relations
   sequence s_wlast; o_write_done ##0 o_empty; endsequence
   sequence s_wgo; o_pending_store_request && i_write_phase && o_ram_select_n; endsequence
   sequence s_rgo; !i_read_phase ##1 i_read_phase && !o_empty && !i_read_hold &&
      !o_pending_store_request && o_ram_select_n; endsequence
   property p_sel; o_ram_select_n == !(o_write_slot_active || o_read_slot_active); endproperty
   property p_rst; $past(i_rst) |-> o_empty && !o_full; endproperty
   property p_req; $rose(o_pending_store_request) |-> !$past(o_full) && !$past(i_write_phase);
   endproperty
   property p_wr; $rose(o_write_slot_active) |-> $past(o_pending_store_request) &&
      $past(i_write_phase); endproperty
   property p_rd; $rose(o_read_slot_active) |-> !$past(o_empty) && !$past(i_read_hold) &&
      $past(i_read_phase) && !$past(i_read_phase, 2); endproperty
   property p_wstep; s_wlast |=> !o_empty; endproperty
   property p_rstep; o_read_done |=> !o_full && !o_read_slot_active; endproperty
   property p_mt; o_empty |-> !o_full; endproperty
   property p_occ_mt; o_empty == (occ == 0); endproperty
   property p_occ_full; o_full == (occ == QUEUE_CAP); endproperty
   property p_wgo; s_wgo |=> o_write_slot_active && !o_read_slot_active; endproperty
   property p_rgo; s_rgo |=> o_read_slot_active; endproperty
   a_sel: assert property (p_sel) else $error("select wrong");
   a_rst: assert property (p_rst) else $error("reset state wrong");
   a_req: assert property (p_req) else $error("request while full");
   a_wr: assert property (p_wr) else $error("write without request");
   a_rd: assert property (p_rd) else $error("read while empty or held");
   a_wstep: assert property (p_wstep) else $error("store pointer idle");
   a_rstep: assert property (p_rstep) else $error("read end wrong");
   a_mt: assert property (p_mt) else $error("empty and full");
   a_occ_mt: assert property (p_occ_mt) else $error("empty flag against fill level");
   a_occ_full: assert property (p_occ_full) else $error("full flag against fill level");
   a_wgo: assert property (p_wgo) else $error("write slot not opened");
   a_rgo: assert property (p_rgo) else $error("read slot not opened");
endmodule
bind cqac_addr_ctrl cqac_addr_ctrl_checker u_chk (.*);

/* tb/cqac_ram_model.sv */
`timescale 1ns/1ps
module cqac_ram_model(input wire logic i_clk, i_sel_n, i_we, i_rd_done,
   input wire logic [15:0] i_addr, output logic o_stale = 0);
   bit valid [0:65535];
   // marks stored places, flags reads of places never written or already read
   always @(posedge i_clk)
      if (!i_sel_n)
      begin
         if (i_we) valid[i_addr] <= 1'b1;
         else o_stale <= !valid[i_addr];
         if (i_rd_done) valid[i_addr] <= 1'b0;
      end
endmodule

/* tb/tb_circular_queue_addr_ctrl.sv */
`timescale 1ns/1ps
module tb_circular_queue_addr_ctrl;
   import cqac_pkg::*;
   logic clk = 0, rst = 1, bp = 0, wp = 0, rp = 0, rh = 0;
   logic req, wact, ract, rdone, sel_n, empty, full, stale;
   logic [15:0] addr, s = 16'h0000;
   logic [15:0] exp_q[$];
   int num_errors = 0, checks_done = 0, seed = 32'he5ca, n;
   always #4 clk = ~clk;
   cqac_addr_ctrl dut (.i_sys_clk(clk), .i_rst(rst), .i_byte_pending(bp), .i_write_phase(wp),
      .i_read_phase(rp), .i_read_hold(rh), .o_pending_store_request(req),
      .o_write_slot_active(wact), .o_read_slot_active(ract), .o_write_done(),
      .o_read_done(rdone), .o_ram_select_n(sel_n), .o_ram_addr(addr), .o_empty(empty),
      .o_full(full));
   cqac_ram_model ram (.i_clk(clk), .i_sel_n(sel_n), .i_we(wact), .i_rd_done(rdone),
      .i_addr(addr), .o_stale(stale));
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1)
      begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one store slot, expected read address noted; both raises the read phase too
   task automatic wr(input logic both);
      int k = 0;
      int len;
      len = 1 + ($unsigned($random(seed)) % 4);
      @(negedge clk) bp = 1;
      while (req !== 1'b1 && k < 20) @(negedge clk) k++;
      chk(req === 1'b1, "store request");
      wp = 1;
      rp = both;
      bp = 0;
      repeat (len) @(negedge clk);
      chk(addr === s && sel_n === 1'b0 && ract === 1'b0, "store slot");
      exp_q.push_back(s);
      s = {s[14:0], ~(s[TAP_A] ^ s[TAP_B] ^ s[TAP_C] ^ s[TAP_D])};
      wp = 0;
      rp = 0;
      @(negedge clk);
   endtask
   // one read phase; act says whether a read slot should be open in it
   task automatic rd(input logic act);
      int len;
      len = 1 + ($unsigned($random(seed)) % 4);
      @(negedge clk) rp = 1;
      repeat (len) @(negedge clk);
      chk(ract === act && sel_n === !act, "read slot");
      rp = 0;
      @(negedge clk);
   endtask
   // each read end takes the oldest noted store address
   always @(posedge clk)
      if (rdone === 1'b1)
      begin
         if (exp_q.size() == 0) chk(1'b0, "read from empty queue");
         else chk(addr === exp_q.pop_front() && !stale, "read address");
      end
   initial
   begin
      #100000 num_errors++;
      summarize();
   end
   initial
   begin
      repeat (16) @(negedge clk);
      rst = 0;
      chk(empty === 1'b1 && full === 1'b0 && sel_n === 1'b1, "reset state");
      rd(1'b0);
      chk(ract === 1'b0, "read while empty");
      for (int j = 0; j < 12; j++)
      begin
         n = 1 + ($unsigned($random(seed)) % 6);
         for (int i = 0; i < n; i++) wr(i[0]);
         chk(empty === 1'b0 && full === 1'b0, "filled");
         rh = 1;
         rd(1'b0);
         rh = 0;
         repeat (n) rd(1'b1);
         chk(empty === 1'b1 && exp_q.size() == 0, "drained");
      end
      // reset in mid-run with bytes still queued, then a fresh start from zero
      repeat (3) wr(1'b0);
      @(negedge clk) rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      exp_q.delete();
      s = PTR_RESET;
      chk(empty === 1'b1 && sel_n === 1'b1 && req === 1'b0, "restart");
      wr(1'b0);
      rd(1'b1);
      chk(empty === 1'b1 && exp_q.size() == 0, "restart drained");
      summarize();
   end
endmodule
